//--- hw/irq_timer_pkg.sv
// Constants and carrier types for the core interrupt and overflow timer block
package irq_timer_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0] TMR_CTRL_IDX = 8'h05;
   localparam logic [7:0] IRQ_CTRL_IDX = 8'h07;
   localparam logic [7:0] CNT_LO_IDX = 8'h08;
   localparam logic [7:0] CNT_HI_IDX = 8'h09;
   localparam logic [7:0] EVT_STAT_IDX = 8'h0A;
   localparam logic [7:0] EVT_MASK_IDX = 8'h0B;
   // core_irq_status_control fields
   localparam int PSUM_BIT = 7;
   localparam int TPIN_FLAG_BIT = 6;
   localparam int OVF_FLAG_BIT = 5;
   localparam int EPIN_FLAG_BIT = 4;
   localparam int PGRP_EN_BIT = 3;
   localparam int TPIN_EN_BIT = 2;
   localparam int OVF_EN_BIT = 1;
   localparam int EPIN_EN_BIT = 0;
   // timer_zero_control fields
   localparam int EPIN_POL_BIT = 7;
   localparam int TPIN_POL_BIT = 6;
   localparam int CLK_SEL_BIT = 5;
   localparam int PS_MSB = 4;
   localparam int PS_LSB = 1;
   // Vector addresses
   localparam logic [7:0] VEC_RESET = 8'h00;
   localparam logic [7:0] VEC_EPIN = 8'h08;
   localparam logic [7:0] VEC_OVF = 8'h10;
   localparam logic [7:0] VEC_TPIN = 8'h18;
   localparam logic [7:0] VEC_PERIPH = 8'h20;
   // Event status bits
   localparam int EVT_EPIN = 0;
   localparam int EVT_OVF = 1;
   localparam int EVT_TPIN = 2;
   localparam int EVT_HAZARD = 3;
   localparam int NUM_EVT = 4;
   // Reset values
   localparam logic [7:0] TMR_CTRL_RST = 8'h00;
   localparam logic [7:0] IRQ_CTRL_RST = 8'h00;
   localparam logic [15:0] CNT_RST = 16'h0000;
   localparam logic [15:0] CNT_MAX = 16'hFFFF;
   localparam logic [7:0] PS_RST = 8'h00;
   localparam logic [NUM_EVT-1:0] EVT_RST = 4'h0;

   typedef struct packed {
      logic valid;
      logic [7:0] addr;
   } vec_s;

   // Last prescaler count for a code: ratio 2**n, any code with top bit set 1:256
   function automatic logic [7:0] ps_last(input logic [3:0] code);
      logic [7:0] r;
      r = code[3] ? 8'hFF : ((8'h01 << code[2:0]) - 8'h01);
      return r;
   endfunction
endpackage

//--- hw/core_irq_status_and_timer.sv
// Core interrupt flags, vector selection and 16-bit overflow timer with APB access
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
// How it works
// - Status register holds core flags and enables
// - Bit 7 ORs enabled peripheral flags, read-only
// - Flags set regardless of enables or global disable
// - Flag set while enable cleared, globals enabled, vectors to 00h
// - Timer pin edge sets flag, vector 18h clears
// - Overflow sets flag, vector 10h clears
// - Edge pin sets flag, vector 08h clears
// - Bit 3 gates all peripheral requests
// - Bits 2..0 enable timer pin, overflow, edge pin
// - 16-bit up counter as two bytes
// - 8-bit prescaler ahead of timer
// - Source select: 1 internal, 0 timer pin
// - Prescale 2**n, top bit set gives 1:256
module core_irq_status_and_timer #(
   parameter int ADDR_W = 12
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic external_edge_pin,
   input wire logic timer_clock_pin,
   input wire logic global_irq_disable,
   input wire logic [7:0] peripheral_request_flags,
   input wire logic [7:0] peripheral_enable_bits,
   input wire logic vector_taken,
   output irq_timer_pkg::vec_s vector_request,
   output logic irq
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   logic [2:0] epin_sync_ff;
   logic [2:0] tpin_sync_ff;
   logic [7:0] tctl_ff, nxt_tctl;
   logic [6:0] ictl_ff, nxt_ictl;
   logic [15:0] cnt_ff, nxt_cnt;
   logic [7:0] ps_ff, nxt_ps;
   logic psum_ff;
   logic hazard_ff, nxt_hazard;
   logic [irq_timer_pkg::NUM_EVT-1:0] evt_ff, nxt_evt, mask_ff, nxt_mask;
   irq_timer_pkg::vec_s vec_ff, nxt_vec;
   logic irq_ff, nxt_irq;
   logic [31:0] prdata_ff, nxt_prdata;
   logic pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
   logic [7:0] idx;
   logic wr, cnt_wr, epin_evt, tpin_evt, src_tick, cnt_tick, ovf, psum, hazard;
   logic [3:0] set_evt, en_clr;

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign vector_request = vec_ff;
   assign irq = irq_ff;

   // Pins cross in through two flops; third flop only feeds edge detection
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         epin_sync_ff <= 3'h0;
         tpin_sync_ff <= 3'h0;
      end else begin
         epin_sync_ff <= {epin_sync_ff[1:0], external_edge_pin};
         tpin_sync_ff <= {tpin_sync_ff[1:0], timer_clock_pin};
      end
   end

   assign idx = paddr[9:2];
   assign wr = psel & penable & pready_ff & pwrite & pstrb[0] & ~pslverr_ff;
   assign cnt_wr = wr & ((idx == irq_timer_pkg::CNT_LO_IDX) |
                         (idx == irq_timer_pkg::CNT_HI_IDX));

   always_comb begin
      epin_evt = tctl_ff[irq_timer_pkg::EPIN_POL_BIT] ?
                 (epin_sync_ff[1] & ~epin_sync_ff[2]) :
                 (~epin_sync_ff[1] & epin_sync_ff[2]);
      tpin_evt = tctl_ff[irq_timer_pkg::TPIN_POL_BIT] ?
                 (tpin_sync_ff[1] & ~tpin_sync_ff[2]) :
                 (~tpin_sync_ff[1] & tpin_sync_ff[2]);
      src_tick = tctl_ff[irq_timer_pkg::CLK_SEL_BIT] ? 1'b1 : tpin_evt;
      cnt_tick = src_tick &
         (ps_ff == irq_timer_pkg::ps_last(tctl_ff[irq_timer_pkg::PS_MSB:irq_timer_pkg::PS_LSB]));
      ovf = cnt_tick & (cnt_ff == irq_timer_pkg::CNT_MAX) & ~cnt_wr;
      psum = |(peripheral_request_flags & peripheral_enable_bits);
      // Flag-setting conditions, in enable bit order 3..0
      set_evt = {psum & ~psum_ff, tpin_evt, ovf, epin_evt};
      en_clr = 4'h0;
      if (wr && idx == irq_timer_pkg::IRQ_CTRL_IDX) begin
         en_clr = ictl_ff[3:0] & ~pwdata[3:0];
      end
      // Enable dropped in the same cycle its flag rises, global disable low: reset vector
      hazard = ~global_irq_disable & |(en_clr & set_evt);
   end

   // Core state: timer, flags, vector and event status
   always_comb begin
      nxt_tctl = tctl_ff;
      nxt_ictl = ictl_ff;
      nxt_cnt = cnt_ff;
      nxt_ps = ps_ff;
      nxt_evt = evt_ff;
      nxt_mask = mask_ff;
      nxt_hazard = hazard_ff;
      if (src_tick) begin
         nxt_ps = cnt_tick ? irq_timer_pkg::PS_RST : 8'(ps_ff + 8'h01);
      end
      if (cnt_tick) begin
         nxt_cnt = 16'(cnt_ff + 16'h0001);
      end
      if (wr) begin
         unique case (idx)
            irq_timer_pkg::TMR_CTRL_IDX: nxt_tctl = {pwdata[7:1], 1'b0};
            irq_timer_pkg::IRQ_CTRL_IDX: nxt_ictl = pwdata[6:0];
            irq_timer_pkg::CNT_LO_IDX: begin
               // Low byte taken from the write data, high byte kept, so a tick in this cycle is lost
               nxt_cnt = {cnt_ff[15:8], pwdata[7:0]};
               nxt_ps = irq_timer_pkg::PS_RST;
            end
            irq_timer_pkg::CNT_HI_IDX: begin
               nxt_cnt = {pwdata[7:0], cnt_ff[7:0]};
               nxt_ps = irq_timer_pkg::PS_RST;
            end
            irq_timer_pkg::EVT_STAT_IDX: nxt_evt = evt_ff & ~pwdata[3:0];
            irq_timer_pkg::EVT_MASK_IDX: nxt_mask = pwdata[3:0];
            default: ;
         endcase
      end
      // Taking vector 00h, 08h, 10h or 18h clears its flag; 20h clears nothing
      if (vector_taken && vec_ff.valid) begin
         unique case (vec_ff.addr)
            irq_timer_pkg::VEC_EPIN: nxt_ictl[irq_timer_pkg::EPIN_FLAG_BIT] = 1'b0;
            irq_timer_pkg::VEC_OVF: nxt_ictl[irq_timer_pkg::OVF_FLAG_BIT] = 1'b0;
            irq_timer_pkg::VEC_TPIN: nxt_ictl[irq_timer_pkg::TPIN_FLAG_BIT] = 1'b0;
            irq_timer_pkg::VEC_RESET: nxt_hazard = 1'b0;
            default: ;
         endcase
      end
      // Sets come last so they win over any clear; enables do not gate them
      if (epin_evt) begin
         nxt_ictl[irq_timer_pkg::EPIN_FLAG_BIT] = 1'b1;
      end
      if (ovf) begin
         nxt_ictl[irq_timer_pkg::OVF_FLAG_BIT] = 1'b1;
      end
      if (tpin_evt) begin
         nxt_ictl[irq_timer_pkg::TPIN_FLAG_BIT] = 1'b1;
      end
      if (hazard) begin
         nxt_hazard = 1'b1;
      end
      nxt_evt = nxt_evt | {hazard, tpin_evt, ovf, epin_evt};
      nxt_irq = |(nxt_evt & nxt_mask);
      // Fixed priority, lowest vector address first
      nxt_vec.valid = 1'b1;
      if (nxt_hazard) begin
         nxt_vec.addr = irq_timer_pkg::VEC_RESET;
      end else if (global_irq_disable) begin
         nxt_vec.valid = 1'b0;
         nxt_vec.addr = irq_timer_pkg::VEC_RESET;
      end else if (nxt_ictl[irq_timer_pkg::EPIN_FLAG_BIT] &
                   nxt_ictl[irq_timer_pkg::EPIN_EN_BIT]) begin
         nxt_vec.addr = irq_timer_pkg::VEC_EPIN;
      end else if (nxt_ictl[irq_timer_pkg::OVF_FLAG_BIT] &
                   nxt_ictl[irq_timer_pkg::OVF_EN_BIT]) begin
         nxt_vec.addr = irq_timer_pkg::VEC_OVF;
      end else if (nxt_ictl[irq_timer_pkg::TPIN_FLAG_BIT] &
                   nxt_ictl[irq_timer_pkg::TPIN_EN_BIT]) begin
         nxt_vec.addr = irq_timer_pkg::VEC_TPIN;
      end else if (psum & nxt_ictl[irq_timer_pkg::PGRP_EN_BIT]) begin
         nxt_vec.addr = irq_timer_pkg::VEC_PERIPH;
      end else begin
         nxt_vec.valid = 1'b0;
         nxt_vec.addr = irq_timer_pkg::VEC_RESET;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tctl_ff <= irq_timer_pkg::TMR_CTRL_RST;
         ictl_ff <= irq_timer_pkg::IRQ_CTRL_RST[6:0];
         cnt_ff <= irq_timer_pkg::CNT_RST;
         ps_ff <= irq_timer_pkg::PS_RST;
         psum_ff <= 1'b0;
         hazard_ff <= 1'b0;
         evt_ff <= irq_timer_pkg::EVT_RST;
         mask_ff <= irq_timer_pkg::EVT_RST;
         vec_ff <= '0;
         irq_ff <= 1'b0;
      end else begin
         tctl_ff <= nxt_tctl;
         ictl_ff <= nxt_ictl;
         cnt_ff <= nxt_cnt;
         ps_ff <= nxt_ps;
         psum_ff <= psum;
         hazard_ff <= nxt_hazard;
         evt_ff <= nxt_evt;
         mask_ff <= nxt_mask;
         vec_ff <= nxt_vec;
         irq_ff <= nxt_irq;
      end
   end

   // Bus answer is prepared in the setup cycle, so access lasts one cycle
   always_comb begin
      nxt_pready = 1'b0;
      nxt_pslverr = 1'b0;
      nxt_prdata = 32'h00000000;
      if (psel && !penable) begin
         nxt_pready = 1'b1;
         unique case (idx)
            irq_timer_pkg::TMR_CTRL_IDX: nxt_prdata[7:0] = tctl_ff;
            irq_timer_pkg::IRQ_CTRL_IDX: nxt_prdata[7:0] = {psum, ictl_ff};
            irq_timer_pkg::CNT_LO_IDX: nxt_prdata[7:0] = cnt_ff[7:0];
            irq_timer_pkg::CNT_HI_IDX: nxt_prdata[7:0] = cnt_ff[15:8];
            irq_timer_pkg::EVT_STAT_IDX: nxt_prdata[3:0] = evt_ff;
            irq_timer_pkg::EVT_MASK_IDX: nxt_prdata[3:0] = mask_ff;
            default: nxt_pslverr = 1'b1;
         endcase
         // Misaligned or out-of-window addresses are unmapped
         if (paddr[1:0] != 2'h0 || (paddr >> 10) != '0) begin
            nxt_pslverr = 1'b1;
            nxt_prdata = 32'h00000000;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h00000000;
      end else begin
         pready_ff <= nxt_pready;
         pslverr_ff <= nxt_pslverr;
         prdata_ff <= nxt_prdata;
      end
   end

   property p_bus_ready;
      psel && !penable |=> pready_ff;
   endproperty
   a_bus_ready: assert property (p_bus_ready) else $error("no ready after setup");

   property p_psum_read;
      psel && !penable && idx == irq_timer_pkg::IRQ_CTRL_IDX && !nxt_pslverr
         |=> prdata_ff[7] == $past(psum);
   endproperty
   a_psum_read: assert property (p_psum_read) else $error("bit 7 not peripheral OR");

   property p_ovf_set;
      ovf |=> ictl_ff[irq_timer_pkg::OVF_FLAG_BIT] && cnt_ff == irq_timer_pkg::CNT_RST;
   endproperty
   a_ovf_set: assert property (p_ovf_set) else $error("overflow flag or wrap wrong");

   property p_epin_set;
      epin_evt |=> ictl_ff[irq_timer_pkg::EPIN_FLAG_BIT];
   endproperty
   a_epin_set: assert property (p_epin_set) else $error("edge pin flag not set");

   property p_tpin_set;
      tpin_evt |=> ictl_ff[irq_timer_pkg::TPIN_FLAG_BIT] && evt_ff[irq_timer_pkg::EVT_TPIN];
   endproperty
   a_tpin_set: assert property (p_tpin_set) else $error("timer pin flag not set");

   property p_hazard;
      hazard |=> vec_ff.valid && vec_ff.addr == irq_timer_pkg::VEC_RESET;
   endproperty
   a_hazard: assert property (p_hazard) else $error("hazard did not vector to 00h");

   property p_gated;
      vec_ff.valid && vec_ff.addr != irq_timer_pkg::VEC_RESET |-> !$past(global_irq_disable);
   endproperty
   a_gated: assert property (p_gated) else $error("vector while globally disabled");

   property p_ovf_clear;
      vector_taken && vec_ff.valid && vec_ff.addr == irq_timer_pkg::VEC_OVF && !ovf
         |=> !ictl_ff[irq_timer_pkg::OVF_FLAG_BIT];
   endproperty
   a_ovf_clear: assert property (p_ovf_clear) else $error("overflow flag not cleared");

   property p_epin_clear;
      vector_taken && vec_ff.valid && vec_ff.addr == irq_timer_pkg::VEC_EPIN && !epin_evt
         |=> !ictl_ff[irq_timer_pkg::EPIN_FLAG_BIT];
   endproperty
   a_epin_clear: assert property (p_epin_clear) else $error("edge pin flag not cleared");

   property p_tpin_clear;
      vector_taken && vec_ff.valid && vec_ff.addr == irq_timer_pkg::VEC_TPIN && !tpin_evt
         |=> !ictl_ff[irq_timer_pkg::TPIN_FLAG_BIT];
   endproperty
   a_tpin_clear: assert property (p_tpin_clear) else $error("timer pin flag not cleared");

   property p_hold;
      !src_tick && !cnt_wr |=> $stable(cnt_ff) && $stable(ps_ff);
   endproperty
   a_hold: assert property (p_hold) else $error("timer moved without a tick");
endmodule

//--- verification/core_fetch_model.sv
// Behavioural model of the core side that accepts interrupt vectors
`timescale 1ns/1ps
module core_fetch_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire irq_timer_pkg::vec_s vector_request,
   input wire logic [3:0] delay,
   output logic vector_taken,
   output logic [7:0] last_vec,
   output int n_taken
);
   logic [3:0] wait_ff;
   // Stall before accepting, so slow cores are covered too
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vector_taken <= 1'b0;
         last_vec <= 8'hFF;
         n_taken <= 0;
         wait_ff <= 4'h0;
      end else begin
         vector_taken <= 1'b0;
         if (vector_request.valid && !vector_taken) begin
            if (wait_ff >= delay) begin
               vector_taken <= 1'b1;
               last_vec <= vector_request.addr;
               n_taken <= n_taken + 1;
               wait_ff <= 4'h0;
            end else begin
               wait_ff <= wait_ff + 4'h1;
            end
         end else begin
            wait_ff <= 4'h0;
         end
      end
   end
endmodule

//--- verification/tb_top.sv
// Testbench for the core interrupt and overflow timer block
`timescale 1ns/1ps
module tb_top;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e;
   logic ext_pin, tmr_pin, gid, taken;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic [3:0] pstrb, dly;
   logic [7:0] pflags, pens, last_vec;
   logic [3:0] codes [3] = '{4'h2, 4'h5, 4'hF};
   irq_timer_pkg::vec_s vreq;
   int n_errors, compares, n_taken, base, ratio;
   core_irq_status_and_timer i_core_irq_status_and_timer (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .external_edge_pin(ext_pin), .timer_clock_pin(tmr_pin), .global_irq_disable(gid),
      .peripheral_request_flags(pflags), .peripheral_enable_bits(pens),
      .vector_taken(taken), .vector_request(vreq), .irq(irq));
   core_fetch_model i_core_fetch_model (.pclk(pclk), .presetn(presetn), .vector_request(vreq),
      .delay(dly), .vector_taken(taken), .last_vec(last_vec), .n_taken(n_taken));
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
      compares++;
      if (g !== x) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", s, x, g);
      end
   endtask
   // One idle cycle after each transfer keeps drives one per time step
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // No wait count assumed; only the watchdog ends a hung access
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h0, d});
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] x);
      apb(1'b0, a, 32'h0);
      chk($sformatf("reg %h", a), {24'h0, x}, r);
   endtask
   task automatic take(input logic [7:0] x);
      while (n_taken <= base) begin
         @(posedge pclk);
      end
      base = n_taken;
      chk("vector", {24'h0, x}, {24'h0, last_vec});
   endtask
   task automatic end_of_test;
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge pclk);
      n_errors++;
      end_of_test();
   end
   initial begin
      {presetn, psel, penable, pwrite, ext_pin, tmr_pin, pflags, pens, dly} = '0;
      {paddr, pwdata, r, e} = '0;
      pstrb = 4'hF;
      gid = 1'b1;
      base = 0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(12'h014, 8'h00);
      rd(12'h01C, 8'h00);
      apb(1'b0, 12'h030, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, e});
      // Flags rise with every enable off and globals disabled
      wr(12'h014, 8'h80);
      ext_pin <= 1'b1;
      repeat (6) @(posedge pclk);
      rd(12'h01C, 8'h10);
      wr(12'h01C, 8'h00);
      wr(12'h014, 8'h00);
      ext_pin <= 1'b0;
      repeat (6) @(posedge pclk);
      rd(12'h01C, 8'h10);
      wr(12'h01C, 8'h11);
      gid <= 1'b0;
      take(irq_timer_pkg::VEC_EPIN);
      rd(12'h01C, 8'h01);
      gid <= 1'b1;
      wr(12'h01C, 8'h37);
      dly <= 4'h3;
      gid <= 1'b0;
      take(irq_timer_pkg::VEC_EPIN);
      take(irq_timer_pkg::VEC_OVF);
      rd(12'h01C, 8'h07);
      gid <= 1'b1;
      wr(12'h01C, 8'h00);
      // Pin-clocked timer, rising polarity
      wr(12'h014, 8'h40);
      tmr_pin <= 1'b1;
      repeat (6) @(posedge pclk);
      rd(12'h020, 8'h01);
      rd(12'h01C, 8'h40);
      wr(12'h01C, 8'h44);
      dly <= 4'h0;
      gid <= 1'b0;
      take(irq_timer_pkg::VEC_TPIN);
      gid <= 1'b1;
      wr(12'h01C, 8'h00);
      // Overflow from FFFF on one pin tick
      wr(12'h024, 8'hFF);
      wr(12'h020, 8'hFF);
      wr(12'h02C, 8'h02);
      tmr_pin <= 1'b0;
      repeat (6) @(posedge pclk);
      tmr_pin <= 1'b1;
      repeat (6) @(posedge pclk);
      rd(12'h01C, 8'h60);
      rd(12'h020, 8'h00);
      rd(12'h024, 8'h00);
      chk("irq", 32'h1, {31'h0, irq});
      wr(12'h02C, 8'h00);
      repeat (2) @(posedge pclk);
      chk("irq masked", 32'h0, {31'h0, irq});
      wr(12'h02C, 8'h02);
      wr(12'h028, 8'h02);
      repeat (2) @(posedge pclk);
      chk("irq cleared", 32'h0, {31'h0, irq});
      rd(12'h028, 8'h05);
      wr(12'h01C, 8'h00);
      // Peripheral summary and its group gate
      pflags <= 8'h81;
      pens <= 8'h01;
      gid <= 1'b0;
      repeat (3) @(posedge pclk);
      rd(12'h01C, 8'h80);
      chk("vreq valid", 32'h0, {31'h0, vreq.valid});
      pens <= 8'h00;
      repeat (2) @(posedge pclk);
      rd(12'h01C, 8'h00);
      pens <= 8'h01;
      wr(12'h01C, 8'h08);
      take(irq_timer_pkg::VEC_PERIPH);
      gid <= 1'b1;
      repeat (2) @(posedge pclk);
      pflags <= 8'h00;
      wr(12'h01C, 8'h00);
      // Internal clock through the prescaler
      for (int i = 0; i < 3; i++) begin
         ratio = codes[i][3] ? 256 : (1 << codes[i][2:0]);
         wr(12'h014, {2'b00, 1'b1, codes[i], 1'b0});
         wr(12'h024, 8'h00);
         wr(12'h020, 8'h00);
         repeat (ratio * 21 / 2 - 1) @(posedge pclk);
         rd(12'h020, 8'h0A);
      end
      // Enable dropped in the cycle its flag rises, globals on
      base = n_taken;
      wr(12'h014, 8'h80);
      wr(12'h01C, 8'h01);
      gid <= 1'b0;
      ext_pin <= 1'b1;
      @(posedge pclk);
      wr(12'h01C, 8'h00);
      take(irq_timer_pkg::VEC_RESET);
      rd(12'h01C, 8'h10);
      rd(12'h028, 8'h0D);
      end_of_test();
   end
endmodule
